//--- design/flash_host.sv
// Host controller driving a byte-wide parallel NOR flash, Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module flash_host
  import flash_host_pkg::*;
#(
  parameter logic [15:0] PROG_TIMEOUT_CYC = `PROG_TIMEOUT_DEF
)
(
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST_N,
  input  wire logic [`AVS_ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic                   I_AVS_READ,
  input  wire logic                   I_AVS_WRITE,
  input  wire logic [31:0]            I_AVS_WRITEDATA,
  output var  logic [31:0]            O_AVS_READDATA,
  output var  logic                   O_AVS_WAITREQUEST,
  output var  logic [`FL_ADDR_W-1:0]  O_FL_ADDR,
  output var  logic                   O_FL_CE_N,
  output var  logic                   O_FL_OE_N,
  output var  logic                   O_FL_WE_N,
  output var  logic [`FL_DATA_W-1:0]  O_FL_DQ_O,
  output var  logic                   O_FL_DQ_OE,
  input  wire logic [`FL_DATA_W-1:0]  I_FL_DQ,
  output var  logic                   O_FL_RESTART_N,
  output var  logic                   O_FL_RESTART_HV,
  input  wire logic                   I_READY_BUSY_N,
  input  wire logic                   I_SUPPLY_OK
);
  host_state_t             r;
  host_state_t             n;
  logic [`SYNC_W-1:0]      pins_q;
  logic [`FL_DATA_W-1:0]   dq_q;
  logic                    ready_q;
  logic                    supply_q;
  logic                    wr_take;
  logic                    ctrl_wr;
  logic [2:0]              op_req;

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  pin_sync u_sync (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_pins  ({I_SUPPLY_OK, I_READY_BUSY_N, I_FL_DQ}),
    .o_pins  (pins_q)
  );

  assign dq_q     = pins_q[`FL_DATA_W-1:0];
  assign ready_q  = pins_q[`SYNC_RB_BIT];
  assign supply_q = pins_q[`SYNC_SUP_BIT];

  // ****************************************************************
  // Command cycle tables
  // ****************************************************************
  function automatic logic [2:0] nwr(input logic [2:0] op);
    logic [2:0] v;
    v = 3'h0;
    unique case (op)
      `OP_PROG:    v = `NWR_PROG;
      `OP_AUTOSEL: v = `NWR_AUTOSEL;
      `OP_RESET:   v = `NWR_RESET;
      default:     v = 3'h0;
    endcase
    return v;
  endfunction

  // Unlock pair, then command, then target cycle for a program; a reset is one target cycle
  function automatic logic [`FL_ADDR_W-1:0] step_addr(
    input logic [2:0]            op,
    input logic [2:0]            step,
    input logic [`FL_ADDR_W-1:0] tgt
  );
    logic [`FL_ADDR_W-1:0] a;
    a = tgt;
    if (op != `OP_RESET)
    begin
      unique case (step)
        3'h0:    a = `UNLOCK1_ADDR;
        3'h1:    a = `UNLOCK2_ADDR;
        3'h2:    a = `UNLOCK1_ADDR;
        default: a = tgt;
      endcase
    end
    return a;
  endfunction

  function automatic logic [`FL_DATA_W-1:0] step_data(
    input logic [2:0]            op,
    input logic [2:0]            step,
    input logic [`FL_DATA_W-1:0] wd
  );
    logic [`FL_DATA_W-1:0] d;
    d = wd;
    if (op == `OP_RESET)
      d = `CMD_RESET;
    else
    begin
      unique case (step)
        3'h0:    d = `UNLOCK1_DATA;
        3'h1:    d = `UNLOCK2_DATA;
        3'h2:    d = (op == `OP_PROG) ? `CMD_PROG : `CMD_AUTOSEL;
        default: d = wd;
      endcase
    end
    return d;
  endfunction

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  assign wr_take = I_AVS_WRITE && !r.av_wait;
  assign ctrl_wr = wr_take && (I_AVS_ADDRESS == `REG_CTRL);
  assign op_req  = I_AVS_WRITEDATA[`CTRL_OP_MSB:`CTRL_OP_LSB];

  function automatic logic [31:0] read_mux(
    input host_state_t           s,
    input logic [`AVS_ADDR_W-1:0] a,
    input logic                  rdy,
    input logic                  sup
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `REG_CTRL:
      begin
        v[`CTRL_OP_MSB:`CTRL_OP_LSB] = s.op;
        v[`CTRL_HV_BIT]              = s.hv;
      end
      `REG_ADDR:  v[`FL_ADDR_W-1:0] = s.addr;
      `REG_WDATA: v[`FL_DATA_W-1:0] = s.wdata;
      `REG_STATUS:
      begin
        v[`ST_BUSY_BIT]    = (s.st != ST_IDLE);
        v[`ST_ERR_BIT]     = s.err;
        v[`ST_AUTOSEL_BIT] = s.autosel;
        v[`ST_READY_BIT]   = rdy;
        v[`ST_SUPPLY_BIT]  = sup;
        v[`ST_HV_BIT]      = s.hv;
        v[`ST_RDATA_LSB +: `FL_DATA_W] = s.rdata;
      end
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n = r;

    // Waitrequest drops for exactly one cycle per request
    n.av_wait = 1'b1;
    if ((I_AVS_READ || I_AVS_WRITE) && r.av_wait)
    begin
      n.av_wait  = 1'b0;
      n.av_rdata = read_mux(r, I_AVS_ADDRESS, ready_q, supply_q);
    end

    if (r.cnt != 16'h0000)
      n.cnt = r.cnt - 16'h0001;

    // Temporary unprotect level follows software at any time
    if (ctrl_wr)
      n.hv = I_AVS_WRITEDATA[`CTRL_HV_BIT];

    unique case (r.st)
      ST_IDLE:
      begin
        if (wr_take && (I_AVS_ADDRESS == `REG_ADDR))
          n.addr = I_AVS_WRITEDATA[`FL_ADDR_W-1:0];
        if (wr_take && (I_AVS_ADDRESS == `REG_WDATA))
          n.wdata = I_AVS_WRITEDATA[`FL_DATA_W-1:0];
        if (ctrl_wr && (op_req != `OP_NONE))
        begin
          if (!supply_q && (op_req != `OP_HWRST))
            n.err = 1'b1;
          else
          begin
            n.err  = 1'b0;
            n.op   = op_req;
            n.step = 3'h0;
            if (op_req == `OP_READ)
            begin
              // Plain reads in autoselect mode return ID codes
              n.st       = ST_R_ACC;
              n.pin_addr = r.addr;
              n.ce_n     = 1'b0;
              n.oe_n     = 1'b0;
              n.cnt      = 16'(`T_ACC_CYC);
            end
            else if (op_req == `OP_HWRST)
            begin
              n.st    = ST_HR_LOW;
              n.rst_n = 1'b0;
              n.cnt   = 16'(`T_RP_CYC);
            end
            else if (nwr(op_req) != 3'h0)
            begin
              n.st       = ST_W_SETUP;
              n.pin_addr = step_addr(op_req, 3'h0, r.addr);
              n.dq_o     = step_data(op_req, 3'h0, r.wdata);
              n.dq_oe    = 1'b1;
              n.ce_n     = 1'b0;
              n.oe_n     = 1'b1;
              n.cnt      = 16'(`T_SETUP_CYC);
            end
            else
              n.err = 1'b1;
          end
        end
      end

      ST_W_SETUP:
      begin
        // Address stable before the later falling strobe
        if (r.cnt == 16'h0000)
        begin
          n.we_n = 1'b0;
          n.st   = ST_W_PULSE;
          n.cnt  = 16'(`T_WP_CYC);
        end
      end

      ST_W_PULSE:
      begin
        if (r.cnt == 16'h0000)
        begin
          n.we_n = 1'b1;
          n.st   = ST_W_HOLD;
          n.cnt  = 16'(`T_WPH_CYC);
        end
      end

      ST_W_HOLD:
      begin
        // Data held past the rising strobe, then bus released
        if (r.cnt == 16'h0000)
        begin
          n.ce_n  = 1'b1;
          n.dq_oe = 1'b0;
          n.step  = r.step + 3'h1;
          n.st    = ST_GAP;
          n.cnt   = 16'(`T_GAP_CYC);
        end
      end

      ST_GAP:
      begin
        if (r.cnt == 16'h0000)
        begin
          if (r.step < nwr(r.op))
          begin
            n.st       = ST_W_SETUP;
            n.pin_addr = step_addr(r.op, r.step, r.addr);
            n.dq_o     = step_data(r.op, r.step, r.wdata);
            n.dq_oe    = 1'b1;
            n.ce_n     = 1'b0;
            n.cnt      = 16'(`T_SETUP_CYC);
          end
          else if (r.op == `OP_PROG)
          begin
            n.st  = ST_BUSY_DLY;
            n.cnt = 16'(`T_BUSY_CYC);
          end
          else if (r.op == `OP_AUTOSEL)
          begin
            n.autosel  = 1'b1;
            n.st       = ST_R_ACC;
            n.pin_addr = r.addr;
            n.ce_n     = 1'b0;
            n.oe_n     = 1'b0;
            n.cnt      = 16'(`T_ACC_CYC);
          end
          else
          begin
            n.autosel = 1'b0;
            n.st      = ST_IDLE;
          end
        end
      end

      ST_BUSY_DLY:
      begin
        if (r.cnt == 16'h0000)
        begin
          n.st  = ST_BUSY_WAIT;
          n.cnt = PROG_TIMEOUT_CYC;
        end
      end

      ST_BUSY_WAIT:
      begin
        // No commands are sent while the device programs
        if (ready_q)
        begin
          n.st       = ST_R_ACC;
          n.pin_addr = r.addr;
          n.ce_n     = 1'b0;
          n.oe_n     = 1'b0;
          n.cnt      = 16'(`T_ACC_CYC);
        end
        else if (r.cnt == 16'h0000)
        begin
          // Software must follow with a reset command
          n.err = 1'b1;
          n.st  = ST_IDLE;
        end
      end

      ST_R_ACC:
      begin
        if (r.cnt == 16'h0000)
        begin
          n.rdata = dq_q;
          n.ce_n  = 1'b1;
          n.oe_n  = 1'b1;
          n.st    = ST_IDLE;
          // Verify catches a refused group or a zero that stayed zero
          if ((r.op == `OP_PROG) && (dq_q != r.wdata))
            n.err = 1'b1;
        end
      end

      ST_HR_LOW:
      begin
        if (r.cnt == 16'h0000)
        begin
          n.rst_n   = 1'b1;
          n.autosel = 1'b0;
          n.st      = ST_HR_REC;
          n.cnt     = 16'(`T_READY_CYC);
        end
      end

      ST_HR_REC:
      begin
        if (r.cnt == 16'h0000)
          n.st = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.ce_n    <= 1'b1;
      r.oe_n    <= 1'b1;
      r.we_n    <= 1'b1;
      r.rst_n   <= 1'b1;
      r.av_wait <= 1'b1;
    end
    else
      r <= n;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_AVS_READDATA    = r.av_rdata;
  assign O_AVS_WAITREQUEST = r.av_wait;
  assign O_FL_ADDR         = r.pin_addr;
  assign O_FL_CE_N         = r.ce_n;
  assign O_FL_OE_N         = r.oe_n;
  assign O_FL_WE_N         = r.we_n;
  assign O_FL_DQ_O         = r.dq_o;
  assign O_FL_DQ_OE        = r.dq_oe;
  assign O_FL_RESTART_N    = r.rst_n;
  assign O_FL_RESTART_HV   = r.hv;
endmodule
`default_nettype wire

//--- common/flash_host_params.svh
// Constants for the parallel NOR flash host controller
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ****************************************************************
// Flash geometry
// ****************************************************************
`define FL_ADDR_W        20
`define FL_DATA_W        8
`define SECTOR_MSB       19
`define SECTOR_LSB       16
`define GROUP_MSB        19
`define GROUP_LSB        17

// ****************************************************************
// Command cycles (defaults, must match the attached device)
// ****************************************************************
`define UNLOCK1_ADDR     20'h00001
`define UNLOCK1_DATA     8'h01
`define UNLOCK2_ADDR     20'h00002
`define UNLOCK2_DATA     8'h02
`define CMD_PROG         8'h10
`define CMD_AUTOSEL      8'h20
`define CMD_RESET        8'h30
`define NWR_PROG         3'h4
`define NWR_AUTOSEL      3'h3
`define NWR_RESET        3'h1

// ****************************************************************
// Timing, ns, and cycle counts at the system clock
// ****************************************************************
`define CLK_PERIOD_NS    10
`define T_SETUP_NS       20
`define T_WP_NS          50
`define T_WPH_NS         30
`define T_GAP_NS         20
`define T_ACC_NS         120
`define T_BUSY_NS        100
`define T_RP_NS          500
`define T_READY_NS       20000
`define CYC_UP(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LAT         3
`define T_SETUP_CYC      `CYC_UP(`T_SETUP_NS)
`define T_WP_CYC         `CYC_UP(`T_WP_NS)
`define T_WPH_CYC        `CYC_UP(`T_WPH_NS)
`define T_GAP_CYC        `CYC_UP(`T_GAP_NS)
`define T_ACC_CYC        (`CYC_UP(`T_ACC_NS) + `SYNC_LAT)
`define T_BUSY_CYC       `CYC_UP(`T_BUSY_NS)
`define T_RP_CYC         `CYC_UP(`T_RP_NS)
`define T_READY_CYC      `CYC_UP(`T_READY_NS)
`define PROG_TIMEOUT_DEF 16'h7530

// ****************************************************************
// Register map and fields
// ****************************************************************
`define AVS_ADDR_W       5
`define REG_CTRL         5'h00
`define REG_ADDR         5'h04
`define REG_WDATA        5'h08
`define REG_STATUS       5'h0c
`define CTRL_OP_MSB      2
`define CTRL_OP_LSB      0
`define CTRL_HV_BIT      8
`define OP_NONE          3'h0
`define OP_READ          3'h1
`define OP_PROG          3'h2
`define OP_AUTOSEL       3'h3
`define OP_RESET         3'h4
`define OP_HWRST         3'h5
`define ST_BUSY_BIT      0
`define ST_ERR_BIT       1
`define ST_AUTOSEL_BIT   2
`define ST_READY_BIT     3
`define ST_SUPPLY_BIT    4
`define ST_HV_BIT        5
`define ST_RDATA_LSB     16
`define SYNC_W           10
`define SYNC_RB_BIT      8
`define SYNC_SUP_BIT     9

`endif

//--- common/flash_host_pkg.sv
// Types for the parallel NOR flash host controller
package flash_host_pkg;
  `include "flash_host_params.svh"

  typedef enum logic [3:0] {
    ST_IDLE, ST_W_SETUP, ST_W_PULSE, ST_W_HOLD, ST_GAP,
    ST_R_ACC, ST_BUSY_DLY, ST_BUSY_WAIT, ST_HR_LOW, ST_HR_REC
  } host_st_t;

  typedef struct packed {
    host_st_t              st;
    logic [2:0]            op;
    logic [2:0]            step;
    logic [15:0]           cnt;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] wdata;
    logic [`FL_DATA_W-1:0] rdata;
    logic                  err;
    logic                  autosel;
    logic                  hv;
    logic [`FL_ADDR_W-1:0] pin_addr;
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
    logic [`FL_DATA_W-1:0] dq_o;
    logic                  dq_oe;
    logic                  rst_n;
    logic                  av_wait;
    logic [31:0]           av_rdata;
  } host_state_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] q;
  } sync_state_t;
endpackage

//--- design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import flash_host_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic [`SYNC_W-1:0] i_pins,
  output var  logic [`SYNC_W-1:0] o_pins
);
  sync_state_t r;
  sync_state_t n;

  // A bit changes only once stages two and three agree
  always_comb
  begin
    n    = r;
    n.s1 = i_pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign o_pins = r.q;
endmodule
`default_nettype wire

//--- test/flash_host_props.sv
// Port assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_props
  import flash_host_pkg::*;
#(
  parameter logic [15:0] PROG_TIMEOUT_CYC = `PROG_TIMEOUT_DEF
)
(
  input wire logic                   I_CLK,
  input wire logic                   I_RST_N,
  input wire logic [`AVS_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic                   I_AVS_READ,
  input wire logic                   I_AVS_WRITE,
  input wire logic [31:0]            I_AVS_WRITEDATA,
  input wire logic                   O_AVS_WAITREQUEST,
  input wire logic [`FL_ADDR_W-1:0]  O_FL_ADDR,
  input wire logic                   O_FL_CE_N,
  input wire logic                   O_FL_OE_N,
  input wire logic                   O_FL_WE_N,
  input wire logic [`FL_DATA_W-1:0]  O_FL_DQ_O,
  input wire logic                   O_FL_DQ_OE,
  input wire logic                   O_FL_RESTART_N,
  input wire logic                   O_FL_RESTART_HV
);
  // ****************************************************************
  // Restart pulse length counter and properties
  // ****************************************************************
  logic [7:0] rst_lo_r;

  always_ff @(posedge I_CLK or negedge I_RST_N)
    if (!I_RST_N)
      rst_lo_r <= 8'h00;
    else
      rst_lo_r <= O_FL_RESTART_N ? 8'h00 : rst_lo_r + 8'h01;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  wait_one_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  answer_next_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
    |=> !O_AVS_WAITREQUEST) else $error("request not answered");
  write_qual_a: assert property (!O_FL_WE_N |-> !O_FL_CE_N && O_FL_OE_N && O_FL_DQ_OE)
    else $error("write strobe without qualifiers");
  no_clash_a: assert property (!O_FL_OE_N |-> !O_FL_DQ_OE && O_FL_WE_N)
    else $error("read while driving data");
  pulse_width_a: assert property ($fell(O_FL_WE_N) |-> !O_FL_WE_N[*6] ##1 O_FL_WE_N)
    else $error("write pulse width wrong");
  addr_setup_a: assert property ($fell(O_FL_WE_N) |-> $past(O_FL_CE_N, 2) == 1'b0)
    else $error("address setup short");
  addr_hold_a: assert property (!O_FL_CE_N && !$past(O_FL_CE_N) |-> $stable(O_FL_ADDR))
    else $error("address moved in cycle");
  data_hold_a: assert property ($rose(O_FL_WE_N) |->
    ($stable(O_FL_DQ_O) && O_FL_DQ_OE && !O_FL_CE_N)[*4] ##1 O_FL_CE_N)
    else $error("write data not held");
  restart_len_a: assert property ($rose(O_FL_RESTART_N) |->
    rst_lo_r == 8'(`T_RP_CYC + 1))
    else $error("restart pulse length wrong");
  restart_quiet_a: assert property (!O_FL_RESTART_N |-> O_FL_CE_N && O_FL_WE_N)
    else $error("access during restart");
  hv_follow_a: assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST &&
    I_AVS_ADDRESS == `REG_CTRL |=> O_FL_RESTART_HV == $past(I_AVS_WRITEDATA[`CTRL_HV_BIT]))
    else $error("high voltage request not applied");

  cover property ($rose(O_FL_RESTART_HV));
  cover property ($fell(O_FL_RESTART_N));
  cover property ($fell(O_FL_OE_N));
endmodule

bind flash_host flash_host_props #(.PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)) props_i (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_FL_ADDR(O_FL_ADDR), .O_FL_CE_N(O_FL_CE_N),
  .O_FL_OE_N(O_FL_OE_N), .O_FL_WE_N(O_FL_WE_N), .O_FL_DQ_O(O_FL_DQ_O),
  .O_FL_DQ_OE(O_FL_DQ_OE), .O_FL_RESTART_N(O_FL_RESTART_N), .O_FL_RESTART_HV(O_FL_RESTART_HV)
);
`default_nettype wire

//--- test/flash_dev_model.sv
// Behavioural model of the byte-wide NOR flash behind the host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h7e, // Arbitrary value
  parameter logic [7:0] PROT_GROUPS = 8'h00
)
(
  input  wire logic [19:0] i_addr,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_restart_n,
  input  wire logic        i_hv,
  input  wire logic        i_supply_ok,
  input  wire logic        i_slow,
  output var  logic [7:0]  o_dq,
  output var  logic        o_rb_n
);
  // ****************************************************************
  // Command decoder, array and embedded program
  // ****************************************************************
  logic [7:0]  mem [logic [19:0]];
  logic [19:0] lat_addr;
  logic [19:0] pa;
  logic [7:0]  pd;
  logic [1:0]  step = 2'h0;
  logic        autosel = 1'b0;
  logic        busy = 1'b0;
  wire         wr_on = !i_ce_n && !i_we_n && i_oe_n;

  assign o_rb_n = !busy;

  function automatic logic [7:0] arr(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  function automatic logic [7:0] id_val(input logic [19:0] a);
    case (a[7:0])
      8'h00: return MAKER_CODE;
      8'h01: return DEVICE_CODE;
      8'h02: return {7'h00, PROT_GROUPS[a[19:17]]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic take(input logic [19:0] a, input logic [7:0] d);
    if (d == `CMD_RESET)
    begin
      step = 2'h0;
      autosel = 1'b0;
    end
    else if (step == 2'h3)
    begin
      step = 2'h0;
      pa = a;
      pd = d;
      busy = 1'b1;
    end
    else if (step == 2'h2 && a == `UNLOCK1_ADDR && d == `CMD_AUTOSEL)
    begin
      step = 2'h0;
      autosel = 1'b1;
    end
    else if (step == 2'h2 && a == `UNLOCK1_ADDR && d == `CMD_PROG)
      step = 2'h3;
    else if (step == 2'h1 && a == `UNLOCK2_ADDR && d == `UNLOCK2_DATA)
      step = 2'h2;
    else
      step = {1'b0, a == `UNLOCK1_ADDR && d == `UNLOCK1_DATA};
  endtask

  always @(negedge i_supply_ok or negedge i_restart_n)
  begin
    step = 2'h0;
    autosel = 1'b0;
    busy = 1'b0;
  end

  always @(posedge wr_on)
    lat_addr = i_addr;

  always @(negedge wr_on)
    if (i_supply_ok && i_restart_n && !busy)
      take(lat_addr, i_dq);

  always @(posedge busy)
  begin
    #(i_slow ? 2000 : 200);
    if (busy && (!PROT_GROUPS[pa[19:17]] || i_hv))
      mem[pa] = arr(pa) & pd;
    busy = 1'b0;
  end

  // Released bus shows a changing pattern, never the last value
  always @(i_addr or i_ce_n or i_oe_n or i_restart_n or autosel or busy)
    if (!i_ce_n && !i_oe_n && i_restart_n && !busy)
      o_dq = autosel ? id_val(i_addr) : arr(i_addr);
    else
      o_dq = (o_dq === 8'hxx) ? 8'h5a : ~o_dq;
endmodule
`default_nettype wire

//--- test/flash_host_tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb_top;
  import flash_host_pkg::*;
  // ****************************************************************
  // Bench signals, design and device model
  // ****************************************************************
  localparam logic [7:0] MAKER  = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h7e; // Arbitrary value
  logic                   clk;
  logic                   rst_n;
  logic [`AVS_ADDR_W-1:0] avs_a;
  logic                   avs_r;
  logic                   avs_w;
  logic [31:0]            avs_d;
  logic                   supply;
  logic                   slow;
  logic                   hv;
  logic [31:0]            st;
  int                     num_errors = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  wire logic [31:0]       rdat;
  wire logic              wait_r;
  wire logic [19:0]       fl_a;
  wire logic              ce_n, oe_n, we_n, dq_oe, rs_n, rs_hv, rb_n;
  wire logic [7:0]        dq_o, dev_dq;
  wire logic [7:0]        dq = dq_oe ? dq_o : dev_dq;

  flash_host #(.PROG_TIMEOUT_CYC(16'h0032)) uut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(avs_a), .I_AVS_READ(avs_r),
    .I_AVS_WRITE(avs_w), .I_AVS_WRITEDATA(avs_d), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wait_r), .O_FL_ADDR(fl_a), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n),
    .O_FL_WE_N(we_n), .O_FL_DQ_O(dq_o), .O_FL_DQ_OE(dq_oe), .I_FL_DQ(dq),
    .O_FL_RESTART_N(rs_n), .O_FL_RESTART_HV(rs_hv), .I_READY_BUSY_N(rb_n),
    .I_SUPPLY_OK(supply));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .PROT_GROUPS(8'h04)) dev (
    .i_addr(fl_a), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq),
    .i_restart_n(rs_n), .i_hv(rs_hv), .i_supply_ok(supply), .i_slow(slow),
    .o_dq(dev_dq), .o_rb_n(rb_n));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_w <= w;
    avs_r <= !w;
    avs_a <= a;
    avs_d <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_r !== 1'b0);
    st = rdat;
    avs_w <= 1'b0;
    avs_r <= 1'b0;
    chk("answer delay", 8'h02, 8'(n));
  endtask

  task automatic op(input logic [2:0] o, input logic [19:0] a, input logic [7:0] d);
    bus(1'b1, `REG_ADDR, {12'h000, a});
    bus(1'b1, `REG_WDATA, {24'h000000, d});
    bus(1'b1, `REG_CTRL, {23'h000000, hv, 5'h00, o});
    do
      bus(1'b0, `REG_STATUS, 32'h00000000);
    while (st[`ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic run(input logic [2:0] o, input logic [19:0] a, input logic [7:0] d,
                     input logic e);
    op(o, a, d);
    chk("error flag", {7'h00, e}, {7'h00, st[`ST_ERR_BIT]});
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] x);
    run(`OP_READ, a, 8'h00, 1'b0);
    chk("read data", x, st[23:16]);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      chk("run time", 8'h00, 8'h01);
      summarize();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    avs_a = 5'h00;
    avs_r = 1'b0;
    avs_w = 1'b0;
    avs_d = 32'h00000000;
    supply = 1'b1;
    slow = 1'b0;
    hv = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, `REG_STATUS, 32'h00000000);
    chk("idle status", 8'h18, st[7:0]);
    bus(1'b0, 5'h10, 32'h00000000);
    chk("unmapped read", 8'h00, st[7:0]);
    run(`OP_AUTOSEL, 20'h40000, 8'h00, 1'b0);
    chk("maker code", MAKER, st[23:16]);
    chk("autoselect flag", 8'h01, {7'h00, st[`ST_AUTOSEL_BIT]});
    rd(20'h40001, DEVICE);
    rd(20'h40002, 8'h01);
    rd(20'h50002, 8'h01);
    rd(20'h60002, 8'h00);
    run(`OP_RESET, 20'h12345, 8'h00, 1'b0);
    rd(20'h40002, 8'hff);
    run(`OP_PROG, 20'h12345, 8'ha5, 1'b0);
    rd(20'h12345, 8'ha5);
    run(`OP_PROG, 20'h12345, 8'h5a, 1'b1);
    rd(20'h12345, 8'h00);
    run(`OP_PROG, 20'h40010, 8'h33, 1'b1);
    rd(20'h40010, 8'hff);
    hv = 1'b1;
    run(`OP_PROG, 20'h40010, 8'h33, 1'b0);
    hv = 1'b0;
    run(`OP_PROG, 20'h50011, 8'h0f, 1'b1);
    rd(20'h40010, 8'h33);
    run(3'h7, 20'h00000, 8'h00, 1'b1);
    slow <= 1'b1;
    run(`OP_PROG, 20'h00100, 8'h11, 1'b1);
    slow <= 1'b0;
    run(`OP_RESET, 20'h00000, 8'h00, 1'b0);
    while (st[`ST_READY_BIT] !== 1'b1)
      bus(1'b0, `REG_STATUS, 32'h00000000);
    rd(20'h00100, 8'h11);
    supply <= 1'b0;
    repeat (6) @(posedge clk);
    run(`OP_READ, 20'h00000, 8'h00, 1'b1);
    chk("supply flag", 8'h00, {7'h00, st[`ST_SUPPLY_BIT]});
    supply <= 1'b1;
    repeat (6) @(posedge clk);
    run(`OP_AUTOSEL, 20'h00000, 8'h00, 1'b0);
    run(`OP_HWRST, 20'h00000, 8'h00, 1'b0);
    chk("autoselect flag", 8'h00, {7'h00, st[`ST_AUTOSEL_BIT]});
    rd(20'h00000, 8'hff);
    summarize();
  end
endmodule
`default_nettype wire
